// >>> src/ccpc_top.sv
// Clock multiplier, clock divide and power mode control with APB registers
// How it works
// - Doubler bit set gives internal clock times two
// - Doubler clear means normal mode, off at reset
// - Doubler register low seven bits read one
// - Control bit7 zero halves clock, one passes
// - Reset clears divide select, divide by two
// - Mode 01 idle: oscillator on, clocks stopped
// - Low-power entry only after sleep with stop
// - Mode 10 standby: oscillator stopped entirely
// - Mode 11 standby, recovery after 64 cycles
// - Bus grant in standby after stabilization
// - Phase clock pad reduced drive select
// - Serial and DMA pin group reduced drive
// - Bus-control and status pins reduced drive
// - Address and data pins reduced drive
`timescale 1ns/1ps
`default_nettype none
module ccpc_top
  import ccpc_pkg::*;
#(
  parameter int SLOW_RECOVERY_CYCLES = CCPC_SLOW_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_fetch,
  input wire logic io_stop,
  input wire logic wake_event,
  input wire logic bus_request_in,
  output logic bus_grant,
  output ccpc_clk_mode_t clk_mode,
  output logic osc_run,
  output logic core_clk_run,
  output logic clock_output_pin,
  output logic sleep_active,
  output ccpc_drive_t pad_drive
);
  // Cycle counts sized for the longest recovery
  localparam int CW = $clog2(SLOW_RECOVERY_CYCLES + CCPC_QUICK_CYCLES + 1);
  localparam logic [CW-1:0] QUICK_CNT = CW'(CCPC_QUICK_CYCLES);
  localparam logic [CW-1:0] SLOW_CNT = CW'(SLOW_RECOVERY_CYCLES);

  logic clock_doubler_enable; // Doubler control bit
  logic [7:0] cpu_clock_power_control; // Control register contents
  logic [1:0] bus_req_sync; // Pin synchroniser
  logic [1:0] wake_sync; // Pin synchroniser
  ccpc_state_t state; // Power sequencer state
  ccpc_state_t next_state; // Power sequencer next state
  logic [CW-1:0] recov_cnt; // Stabilisation countdown
  logic stable_done; // Stabilisation timer expired
  logic [1:0] power_mode; // {bit6, bit3}
  logic wr_en; // APB write strobe in access phase
  logic rd_en; // APB read strobe in access phase
  logic hit_dbl; // Address decodes doubler register
  logic hit_ctl; // Address decodes control register
  logic [31:0] next_prdata; // Read mux

  assign power_mode = {cpu_clock_power_control[CCPC_BIT_PM_HI],
                       cpu_clock_power_control[CCPC_BIT_PM_LO]};
  // A write lands on the edge where the master sees pready high
  assign wr_en = psel && penable && pwrite && pready;
  // Read data is loaded a cycle early so that it stands with pready
  assign rd_en = psel && penable && !pwrite && !pready;
  // Timer at zero means the clock is taken as stable
  assign stable_done = (recov_cnt == '0);

  // Address decode on the full byte address
  // Full compare, so no alias of either register answers
  always_comb
  begin
    hit_dbl = 1'b0;
    hit_ctl = 1'b0;
    if (paddr == CCPC_ADDR_DOUBLER)
    begin
      hit_dbl = 1'b1;
    end
    else if (paddr == CCPC_ADDR_CPUCTL)
    begin
      hit_ctl = 1'b1;
    end
  end

  // Read mux; unmapped reads return zero
  // Only the low byte carries data; upper bits read zero
  always_comb
  begin
    next_prdata = CCPC_ZERO32;
    if (hit_dbl)
    begin
      next_prdata[7:0] = {clock_doubler_enable, CCPC_DOUBLER_RSVD};
    end
    else if (hit_ctl)
    begin
      next_prdata[7:0] = cpu_clock_power_control;
    end
  end

  // APB handshake: one wait state, ready pulses one cycle
  // The !pready term stops a held request from answering twice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= CCPC_ZERO32;
    end
    else if (clk_en)
    begin
      pready <= psel && penable && !pready;
      // Unmapped addresses answer with an error
      pslverr <= psel && penable && !pready && !(hit_dbl || hit_ctl);
      if (rd_en)
      begin
        prdata <= next_prdata;
      end
    end
  end

  // Doubler control bit, disabled after power-up
  // Writes to the reserved bits are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_doubler_enable <= 1'b0;
    end
    else if (clk_en && wr_en && hit_dbl)
    begin
      clock_doubler_enable <= pwdata[CCPC_BIT_X2];
    end
  end

  // Control register, all fields cleared at reset
  // Every bit is read/write; the fields act from the next cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_clock_power_control <= CCPC_CPUCTL_RST;
    end
    else if (clk_en && wr_en && hit_ctl)
    begin
      cpu_clock_power_control <= pwdata[7:0];
    end
  end

  // Two-flop synchronisers for external pins
  // Only the second stage is read, the first may be metastable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_req_sync <= 2'b00;
      wake_sync <= 2'b00;
    end
    else if (clk_en)
    begin
      bus_req_sync <= {bus_req_sync[0], bus_request_in};
      wake_sync <= {wake_sync[0], wake_event};
    end
  end

  // Power sequencer next state
  // Exit from each low-power state waits for the synced wake pin
  always_comb
  begin
    next_state = state;
    case (state)
      CCPC_ST_RUN:
      begin
        // Entry only on the second sleep opcode with stop set
        if (sleep_fetch && io_stop)
        begin
          if (power_mode == CCPC_PM_IDLE)
          begin
            next_state = CCPC_ST_IDLE;
          end
          else if (power_mode == CCPC_PM_NONE)
          begin
            next_state = CCPC_ST_SLEEP;
          end
          else
          begin
            next_state = CCPC_ST_STBY;
          end
        end
      end
      CCPC_ST_SLEEP:
      begin
        // Plain sleep keeps clocks, only the flag is shown
        if (wake_sync[1])
        begin
          next_state = CCPC_ST_RUN;
        end
      end
      CCPC_ST_IDLE:
      begin
        // Oscillator never stopped, so no recovery wait
        if (wake_sync[1])
        begin
          next_state = CCPC_ST_RUN;
        end
      end
      CCPC_ST_STBY:
      begin
        // Oscillator restarts first, core waits in recovery
        if (wake_sync[1])
        begin
          next_state = CCPC_ST_RECOV;
        end
      end
      CCPC_ST_RECOV:
      begin
        // Core clock returns only once the timer has run out
        if (stable_done)
        begin
          next_state = CCPC_ST_RUN;
        end
      end
      default:
      begin
        // Unreachable code from an upset falls back to run
        next_state = CCPC_ST_RUN;
      end
    endcase
  end

  // Sequencer state register
  // Frozen with everything else while clk_en is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= CCPC_ST_RUN;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  // Stabilisation timer: loaded on standby entry, counts while stopped
  // Counting during standby too lets a bus request see an expired timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      recov_cnt <= '0;
    end
    else if (clk_en)
    begin
      // Standby entry: grant timer starts from the slow count
      if (state == CCPC_ST_RUN && next_state == CCPC_ST_STBY)
      begin
        recov_cnt <= SLOW_CNT;
      end
      else if (state == CCPC_ST_STBY && next_state == CCPC_ST_RECOV)
      begin
        if (power_mode == CCPC_PM_QUICK)
        begin
          recov_cnt <= QUICK_CNT - CW'(1);
        end
        else
        begin
          recov_cnt <= SLOW_CNT - CW'(1);
        end
      end
      // Otherwise count down to zero and hold there
      else if (!stable_done)
      begin
        recov_cnt <= recov_cnt - CW'(1);
      end
    end
  end

  // Clock, pad and grant outputs, all registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_mode <= CCPC_CLK_DIV2;
      osc_run <= 1'b1;
      core_clk_run <= 1'b1;
      clock_output_pin <= 1'b1;
      sleep_active <= 1'b0;
      bus_grant <= 1'b0;
      pad_drive <= '0;
    end
    else if (clk_en)
    begin
      // Doubler takes priority over the divide select
      if (clock_doubler_enable)
      begin
        clk_mode <= CCPC_CLK_X2;
      end
      else if (cpu_clock_power_control[CCPC_BIT_DIV1])
      begin
        clk_mode <= CCPC_CLK_DIV1;
      end
      else
      begin
        clk_mode <= CCPC_CLK_DIV2;
      end
      // Outputs follow next_state so they change on the entry edge
      osc_run <= !(next_state == CCPC_ST_STBY);
      core_clk_run <= (next_state == CCPC_ST_RUN) ||
                      (next_state == CCPC_ST_SLEEP);
      clock_output_pin <= (next_state == CCPC_ST_RUN) ||
                          (next_state == CCPC_ST_SLEEP);
      sleep_active <= (next_state == CCPC_ST_SLEEP);
      // No grant while the core itself runs
      if (state == CCPC_ST_RUN)
      begin
        bus_grant <= 1'b0;
      end
      else
      begin
        // Grant drops on the exit edge, the same edge on which the oscillator restarts
        bus_grant <= cpu_clock_power_control[CCPC_BIT_BGNT] &&
                     state == CCPC_ST_STBY &&
                     next_state == CCPC_ST_STBY && stable_done &&
                     bus_req_sync[1];
      end
      // Pad low-drive selects mirror the control register bits
      pad_drive.phase_clock_low_drive <=
        cpu_clock_power_control[CCPC_BIT_LNPH];
      pad_drive.serial_pin_low_drive <=
        cpu_clock_power_control[CCPC_BIT_LNSER];
      pad_drive.control_pin_low_drive <=
        cpu_clock_power_control[CCPC_BIT_LNCTL];
      pad_drive.addr_data_low_drive <=
        cpu_clock_power_control[CCPC_BIT_LNAD];
    end
  end
endmodule
`default_nettype wire

// >>> src/ccpc_pkg.sv
// Package with register map, fields and timing for the clock/power control
package ccpc_pkg;
  // Register indices; each register is one word, so the byte address
  // is four times the index
  localparam logic [7:0] CCPC_IDX_DOUBLER = 8'h1e;
  localparam logic [7:0] CCPC_IDX_CPUCTL = 8'h1f;
  localparam logic [11:0] CCPC_ADDR_DOUBLER = {2'b00, CCPC_IDX_DOUBLER, 2'b00};
  localparam logic [11:0] CCPC_ADDR_CPUCTL = {2'b00, CCPC_IDX_CPUCTL, 2'b00};
  // Field positions
  localparam int CCPC_BIT_X2 = 7;
  localparam int CCPC_BIT_DIV1 = 7;
  localparam int CCPC_BIT_PM_HI = 6;
  localparam int CCPC_BIT_BGNT = 5;
  localparam int CCPC_BIT_LNPH = 4;
  localparam int CCPC_BIT_PM_LO = 3;
  localparam int CCPC_BIT_LNSER = 2;
  localparam int CCPC_BIT_LNCTL = 1;
  localparam int CCPC_BIT_LNAD = 0;
  // Reset values and read masks
  localparam logic [7:0] CCPC_CPUCTL_RST = 8'h00;
  localparam logic [6:0] CCPC_DOUBLER_RSVD = 7'h7f;
  localparam logic [31:0] CCPC_ZERO32 = 32'h0000_0000;
  // Recovery timing in clock cycles
  localparam int CCPC_QUICK_CYCLES = 64;
  localparam int CCPC_SLOW_CYCLES = 1024;
  // Power mode encodings {bit6, bit3}
  localparam logic [1:0] CCPC_PM_NONE = 2'b00;
  localparam logic [1:0] CCPC_PM_IDLE = 2'b01;
  localparam logic [1:0] CCPC_PM_STBY = 2'b10;
  localparam logic [1:0] CCPC_PM_QUICK = 2'b11;
  // Clock mode select driven to the clock generator
  typedef enum logic [1:0]
  {
    CCPC_CLK_DIV2 = 2'b00,
    CCPC_CLK_DIV1 = 2'b01,
    CCPC_CLK_X2 = 2'b10
  } ccpc_clk_mode_t;
  // Pad low-drive selects
  typedef struct packed
  {
    logic phase_clock_low_drive;
    logic serial_pin_low_drive;
    logic control_pin_low_drive;
    logic addr_data_low_drive;
  } ccpc_drive_t;
  // Power sequencer states, one-hot
  typedef enum logic [4:0]
  {
    CCPC_ST_RUN = 5'b00001,
    CCPC_ST_SLEEP = 5'b00010,
    CCPC_ST_IDLE = 5'b00100,
    CCPC_ST_STBY = 5'b01000,
    CCPC_ST_RECOV = 5'b10000
  } ccpc_state_t;
endpackage

// >>> test/ccpc_checker.sv
// Port checks for the clock and power control block
`timescale 1ns/1ps
`default_nettype none
module ccpc_checker
  import ccpc_pkg::*;
#(
  parameter int SLOW_RECOVERY_CYCLES = CCPC_SLOW_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_fetch,
  input wire logic io_stop,
  input wire logic bus_grant,
  input wire logic osc_run,
  input wire logic core_clk_run,
  input wire logic clock_output_pin,
  input wire logic sleep_active
);
  // One clock domain, so one default clocking and disable
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Answer is a single-cycle pulse
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  // One wait state, never more
  ready_wait_a: assert property (psel && penable && !pready && clk_en
    |=> pready)
    else $error("pready missing one cycle after access");
  // Error flag only rides on the answer
  error_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // Output pin mirrors the internal clock gate
  clock_output_pin_gate_a: assert property (clock_output_pin == core_clk_run)
    else $error("clock output pin differs from core clock");
  // A stopped oscillator leaves nothing clocked
  stby_osc_a: assert property (!osc_run |-> !core_clk_run)
    else $error("core clock runs with oscillator stopped");
  // Clocks stop only right after a sleep fetch with stop set
  sleep_entry_a: assert property ($fell(core_clk_run) |->
    $past(sleep_fetch && io_stop && clk_en))
    else $error("clock stopped without sleep request");
  plain_sleep_a: assert property ($rose(sleep_active) |->
    $past(sleep_fetch && io_stop))
    else $error("plain sleep entered without sleep request");
  // Grant only while in standby
  grant_stby_a: assert property (bus_grant |-> !osc_run)
    else $error("bus grant outside standby");
  // Grant waits for the stabilization timer
  grant_timer_a: assert property ($rose(bus_grant) |->
    $past(!osc_run, SLOW_RECOVERY_CYCLES))
    else $error("bus grant before timer expired");
endmodule
bind ccpc_top ccpc_checker #(
  .SLOW_RECOVERY_CYCLES(SLOW_RECOVERY_CYCLES)
) ccpc_checker_i (
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .sleep_fetch(sleep_fetch),
  .io_stop(io_stop),
  .bus_grant(bus_grant),
  .osc_run(osc_run),
  .core_clk_run(core_clk_run),
  .clock_output_pin(clock_output_pin),
  .sleep_active(sleep_active)
);
`default_nettype wire

// >>> test/tb_ccpc_top.sv
// Self-checking bench for the clock and power control block
`timescale 1ns/1ps
`default_nettype none
module tb_ccpc_top;
  import ccpc_pkg::*;
  localparam int SLOW = 8; // Short slow recovery keeps the run brief
  localparam logic [7:0] LN[4] = '{8'h10, 8'h04, 8'h02, 8'h01};
  logic pclk = 0, presetn = 0, clk_en = 1;
  logic psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, sleep_fetch = 0, io_stop = 0;
  logic wake_event = 0, bus_request_in = 0, bus_grant;
  logic osc_run, core_clk_run, clock_output_pin, sleep_active;
  ccpc_clk_mode_t clk_mode;
  ccpc_drive_t pad_drive;
  int num_errors = 0, cmp_count = 0, n;
  ccpc_top #(.SLOW_RECOVERY_CYCLES(SLOW)) ccpc_top_i (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sleep_fetch(sleep_fetch),
    .io_stop(io_stop),
    .wake_event(wake_event),
    .bus_request_in(bus_request_in),
    .bus_grant(bus_grant),
    .clk_mode(clk_mode),
    .osc_run(osc_run),
    .core_clk_run(core_clk_run),
    .clock_output_pin(clock_output_pin),
    .sleep_active(sleep_active),
    .pad_drive(pad_drive)
  );
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Second sleep opcode fetched, with the stop bit as given
  task automatic slp(input logic s);
    @(posedge pclk);
    io_stop <= s;
    sleep_fetch <= 1'b1;
    @(posedge pclk);
    sleep_fetch <= 1'b0;
    @(posedge pclk);
  endtask
  // Raise the exit condition; n counts recovery cycles
  task automatic wake();
    wake_event <= 1'b1;
    while (osc_run !== 1'b1) @(posedge pclk);
    n = 0;
    while (core_clk_run !== 1'b1 || sleep_active !== 1'b0)
    begin
      @(posedge pclk);
      n++;
    end
    wake_event <= 1'b0;
    tick(4); // Let the synchronizer drain before the next sleep
  endtask
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    tick(6);
    presetn <= 1'b1;
    tick(1);
    chk(clk_mode, CCPC_CLK_DIV2);
    chk({osc_run, core_clk_run}, 2'h3);
    apb(0, CCPC_ADDR_DOUBLER, 8'h00);
    chk(rd, 32'h0000_007f);
    apb(0, CCPC_ADDR_CPUCTL, 8'h00);
    chk(rd, CCPC_CPUCTL_RST);
    apb(1, CCPC_ADDR_DOUBLER, 8'h80);
    apb(0, CCPC_ADDR_DOUBLER, 8'h00);
    chk(rd, 32'h0000_00ff);
    chk(clk_mode, CCPC_CLK_X2);
    apb(1, CCPC_ADDR_DOUBLER, 8'h00);
    apb(1, CCPC_ADDR_CPUCTL, 8'h80);
    apb(0, CCPC_ADDR_CPUCTL, 8'h00);
    chk(rd, 32'h0000_0080);
    chk(clk_mode, CCPC_CLK_DIV1);
    apb(0, 12'h010, 8'h00);
    chk(err, 1'b1);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      apb(1, CCPC_ADDR_CPUCTL, LN[i]);
      tick(2);
      chk(pad_drive, 4'h8 >> i);
    end
    // Idle: no entry without the stop bit
    apb(1, CCPC_ADDR_CPUCTL, 8'h08);
    slp(1'b0);
    chk(core_clk_run, 1'b1);
    slp(1'b1);
    chk({osc_run, core_clk_run, clock_output_pin}, 3'h4);
    wake();
    // Quick standby, grant disabled
    apb(1, CCPC_ADDR_CPUCTL, 8'h48);
    slp(1'b1);
    bus_request_in <= 1'b1;
    chk({osc_run, core_clk_run}, 2'h0);
    tick(SLOW + 8);
    chk(bus_grant, 1'b0);
    wake();
    chk(n, CCPC_QUICK_CYCLES);
    // Standby with grant enabled, request still high
    apb(1, CCPC_ADDR_CPUCTL, 8'h60);
    slp(1'b1);
    chk({osc_run, bus_grant}, 2'h0);
    tick(SLOW + 8);
    chk(bus_grant, 1'b1);
    wake();
    chk(n, SLOW);
    bus_request_in <= 1'b0;
    chk(bus_grant, 1'b0);
    // Plain sleep when neither mode is enabled
    apb(1, CCPC_ADDR_CPUCTL, 8'h00);
    slp(1'b1);
    chk({sleep_active, osc_run}, 2'h3);
    wake();
    chk(sleep_active, 1'b0);
    // Clock enable low: a sleep request must not move the sequencer
    clk_en <= 1'b0;
    slp(1'b1);
    chk(sleep_active, 1'b0);
    clk_en <= 1'b1;
    tick(1);
    chk(sleep_active, 1'b0);
    finish_test();
  end
  // Watchdog: the sequence needs well under 2000 cycles
  initial
  begin
    #400_000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
